// ==== src/ebi_consts.vh ====
`ifndef EBI_CONSTS_VH
`define EBI_CONSTS_VH
// =========================================================
// address map
`define EBI_INT_SRAM_TOP 16'h10ff
`define EBI_EXT_BASE 16'h1100
// =========================================================
// wait-select codes
`define EBI_WAIT_NONE 2'h0
`define EBI_WAIT_ONE 2'h1
`define EBI_WAIT_TWO 2'h2
`define EBI_WAIT_TWO_GAP 2'h3
// =========================================================
// strobe wait counts
`define EBI_CNT_NONE 2'h0
`define EBI_CNT_ONE 2'h1
`define EBI_CNT_TWO 2'h2
// =========================================================
// reset values
`define EBI_RST_BYTE 8'h00
`define EBI_RST_ADDR 16'h0000
`define EBI_RST_WAIT 2'h0
// =========================================================
// sequencer states
`define EBI_ST_IDLE 3'h0
`define EBI_ST_ADDR 3'h1
`define EBI_ST_LATCH 3'h2
`define EBI_ST_STROBE 3'h3
`define EBI_ST_GAP 3'h4
`endif

// ==== src/ebi_core.v ====
`include "ebi_consts.vh"
`default_nettype none
module ebi_core (
  input wire sys_clk,
  input wire rst,
  // core access side
  input wire acc_req,
  input wire acc_we,
  input wire [15:0] acc_addr,
  input wire [7:0] acc_wdata,
  output wire acc_is_ext,
  output wire acc_busy,
  output wire acc_done,
  output wire [7:0] acc_rdata,
  // configuration bits
  input wire ext_mem_enable,
  input wire legacy_mode,
  input wire [1:0] upper_wait_select,
  input wire [1:0] lower_wait_select,
  input wire [2:0] sector_split_select,
  input wire [2:0] high_addr_release,
  input wire bus_keeper_enable,
  // ordinary port settings
  input wire [7:0] port_out_ad,
  input wire [7:0] port_dir_ad,
  input wire [7:0] port_out_hi,
  input wire [7:0] port_dir_hi,
  input wire [2:0] port_out_ctl,
  input wire [2:0] port_dir_ctl,
  // pins
  input wire [7:0] mux_addr_data_bus_in,
  output wire [7:0] mux_addr_data_bus_out,
  output wire [7:0] mux_addr_data_bus_oe,
  output wire [7:0] mux_addr_data_bus_pullup,
  output wire mux_addr_data_bus_keeper,
  output wire [7:0] high_addr_bus_out,
  output wire [7:0] high_addr_bus_oe,
  output wire ale_out,
  output wire ale_oe,
  output wire rd_n_out,
  output wire rd_n_oe,
  output wire wr_n_out,
  output wire wr_n_oe
);
  // =========================================================
  // helper functions
  function [1:0] wait_cycles;
    input [1:0] code;
    begin
      case (code)
        `EBI_WAIT_NONE: wait_cycles = `EBI_CNT_NONE;
        `EBI_WAIT_ONE: wait_cycles = `EBI_CNT_ONE;
        default: wait_cycles = `EBI_CNT_TWO;
      endcase
    end
  endfunction

  function in_upper_sector;
    input [2:0] split;
    input [15:0] addr;
    begin
      in_upper_sector = (split == 3'h0) || (addr[15:13] >= split);
    end
  endfunction

  function pin_pick;
    input use_bus;
    input bus_val;
    input port_val;
    begin
      pin_pick = use_bus ? bus_val : port_val;
    end
  endfunction

  function ctl_drive;
    input use_bus;
    input out_only;
    input port_dir;
    begin
      ctl_drive = use_bus | out_only | port_dir;
    end
  endfunction

  // =========================================================
  // configuration after legacy restrictions
  wire [7:0] ad_pins;
  wire [1:0] eff_upper_code;
  wire [1:0] eff_lower_code;
  wire [2:0] eff_split;
  wire [2:0] eff_release;
  wire [1:0] sel_code;
  wire [7:0] hi_mask;

  ebi_sync2 #(.WIDTH(8)) u_ad_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(mux_addr_data_bus_in),
    .sync_out(ad_pins)
  );

  assign eff_upper_code = legacy_mode ? {1'b0, upper_wait_select[0]} : upper_wait_select;
  assign eff_lower_code = legacy_mode ? `EBI_RST_WAIT : lower_wait_select;
  assign eff_split = legacy_mode ? 3'h0 : sector_split_select;
  assign eff_release = legacy_mode ? 3'h0 : high_addr_release;
  assign sel_code = in_upper_sector(eff_split, acc_addr) ? eff_upper_code : eff_lower_code;
  // top lines released to the port
  assign hi_mask = 8'hff >> eff_release;

  assign acc_is_ext = (acc_addr > `EBI_INT_SRAM_TOP);

  // =========================================================
  // bus sequencer
  reg [2:0] state_reg;
  reg [1:0] cnt_reg;
  reg [1:0] code_reg;
  reg we_reg;
  reg ext_reg;
  reg done_reg;
  reg [7:0] rdata_reg;
  reg ale_reg;
  reg rd_n_reg;
  reg wr_n_reg;
  reg ad_drive_reg;
  reg [7:0] ad_val_reg;
  reg [7:0] hi_val_reg;
  reg hi_drive_reg;

  always @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= `EBI_ST_IDLE;
      cnt_reg <= 2'h0;
      code_reg <= `EBI_RST_WAIT;
      we_reg <= 1'b0;
      ext_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= `EBI_RST_BYTE;
      ale_reg <= 1'b0;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      ad_drive_reg <= 1'b0;
      ad_val_reg <= `EBI_RST_BYTE;
      hi_val_reg <= `EBI_RST_BYTE;
      hi_drive_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        `EBI_ST_IDLE: begin
          if (!ext_mem_enable) begin
            // nothing stays driven for a later enable
            hi_drive_reg <= 1'b0;
          end
          if (acc_req) begin
            if (!ext_mem_enable) begin
              // external reads give zero, never alias
              done_reg <= 1'b1;
              rdata_reg <= `EBI_RST_BYTE;
            end else begin
              state_reg <= `EBI_ST_ADDR;
              ale_reg <= 1'b1;
              ad_drive_reg <= 1'b1;
              ad_val_reg <= acc_addr[7:0];
              hi_val_reg <= acc_addr[15:8];
              hi_drive_reg <= 1'b1;
              we_reg <= acc_we;
              ext_reg <= acc_is_ext;
              code_reg <= sel_code;
              cnt_reg <= wait_cycles(sel_code);
            end
          end
        end
        `EBI_ST_ADDR: begin
          // address stays on bus as strobe falls
          state_reg <= `EBI_ST_LATCH;
          ale_reg <= 1'b0;
        end
        `EBI_ST_LATCH: begin
          if (ext_reg) begin
            // latch stays low in data phase
            state_reg <= `EBI_ST_STROBE;
            rd_n_reg <= we_reg;
            wr_n_reg <= ~we_reg;
            ad_drive_reg <= we_reg;
            if (we_reg) begin
              ad_val_reg <= acc_wdata;
            end
          end else begin
            state_reg <= `EBI_ST_IDLE;
            ad_drive_reg <= 1'b0;
            done_reg <= 1'b1;
          end
        end
        `EBI_ST_STROBE: begin
          if (cnt_reg == 2'h0) begin
            rd_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            ad_drive_reg <= 1'b0;
            if (!we_reg) begin
              rdata_reg <= ad_pins;
            end
            if (code_reg == `EBI_WAIT_TWO_GAP) begin
              state_reg <= `EBI_ST_GAP;
            end else begin
              state_reg <= `EBI_ST_IDLE;
              done_reg <= 1'b1;
            end
          end else begin
            cnt_reg <= cnt_reg - 2'h1;
          end
        end
        `EBI_ST_GAP: begin
          // one idle cycle before next address
          state_reg <= `EBI_ST_IDLE;
          done_reg <= 1'b1;
        end
        default: begin
          state_reg <= `EBI_ST_IDLE;
        end
      endcase
    end
  end

  assign acc_busy = (state_reg != `EBI_ST_IDLE);
  assign acc_done = done_reg;
  assign acc_rdata = rdata_reg;

  // =========================================================
  // pin multiplexing
  wire ctl_out_only;
  assign ctl_out_only = legacy_mode;

  assign mux_addr_data_bus_out = ext_mem_enable ? ad_val_reg : port_out_ad;
  assign mux_addr_data_bus_oe = ext_mem_enable ? {8{ad_drive_reg}} : port_dir_ad;
  assign mux_addr_data_bus_pullup = port_out_ad & ~mux_addr_data_bus_oe;
  assign mux_addr_data_bus_keeper = bus_keeper_enable & ~legacy_mode;

  reg [7:0] hi_out_mux;
  reg [7:0] hi_oe_mux;

  always @* begin
    hi_out_mux = port_out_hi;
    hi_oe_mux = port_dir_hi;
    if (ext_mem_enable) begin
      // released lines stay ordinary port pins
      hi_out_mux = (hi_val_reg & hi_mask) | (port_out_hi & ~hi_mask);
      hi_oe_mux = ({8{hi_drive_reg}} & hi_mask) | (port_dir_hi & ~hi_mask);
    end
  end

  assign high_addr_bus_out = hi_out_mux;
  assign high_addr_bus_oe = hi_oe_mux;

  // strobe pins output only in legacy
  assign ale_out = pin_pick(ext_mem_enable, ale_reg, port_out_ctl[2]);
  assign ale_oe = ctl_drive(ext_mem_enable, ctl_out_only, port_dir_ctl[2]);
  assign rd_n_out = pin_pick(ext_mem_enable, rd_n_reg, port_out_ctl[1]);
  assign rd_n_oe = ctl_drive(ext_mem_enable, ctl_out_only, port_dir_ctl[1]);
  assign wr_n_out = pin_pick(ext_mem_enable, wr_n_reg, port_out_ctl[0]);
  assign wr_n_oe = ctl_drive(ext_mem_enable, ctl_out_only, port_dir_ctl[0]);
endmodule // ebi_core
`default_nettype wire

// ==== src/ebi_sync2.v ====
`default_nettype none
// =========================================================
// two-stage synchroniser for pin inputs
module ebi_sync2 #(
  parameter WIDTH = 8
) (
  input wire sys_clk,
  input wire rst,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;
  always @(posedge sys_clk) begin
    if (rst) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end
  assign sync_out = sync_reg;
endmodule // ebi_sync2
`default_nettype wire

// ==== verification/ebi_core_bench.sv ====
`default_nettype none
module ebi_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {int lat; logic [7:0] d; int t0;} ebi_note_t;
  logic sys_clk = 1'b0;
  logic rst, acc_req, acc_we, acc_is_ext, acc_busy, acc_done, legacy_mode;
  logic ext_mem_enable, bus_keeper_enable, mux_addr_data_bus_keeper;
  logic ale_out, ale_oe, rd_n_out, rd_n_oe, wr_n_out, wr_n_oe;
  logic [15:0] acc_addr;
  logic [7:0] acc_wdata, acc_rdata, port_out_ad, port_dir_ad, port_out_hi, port_dir_hi;
  logic [7:0] mux_addr_data_bus_in, mux_addr_data_bus_out, mux_addr_data_bus_oe;
  logic [7:0] mux_addr_data_bus_pullup, high_addr_bus_out, high_addr_bus_oe;
  logic [2:0] port_out_ctl, port_dir_ctl, sector_split_select, high_addr_release;
  logic [1:0] upper_wait_select, lower_wait_select;
  logic [7:0] lr, d [0:3];
  int num_errors = 0, check_count = 0, cyc = 0, i;
  ebi_note_t q [$];
  ebi_note_t n;
  ebi_core u_dut (.*);
  ebi_mem_model u_mem (.*);
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  // ====
  // tasks
  task automatic check(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] wd,
                     input int l, input logic [7:0] x);
    int k;
    acc_req <= 1'b1;
    acc_we <= w;
    acc_addr <= a;
    acc_wdata <= wd;
    @(posedge sys_clk);
    q.push_back('{l, x, cyc});
    acc_req <= 1'b0;
    for (k = 0; k < 20 && acc_done !== 1'b1; k++) @(negedge sys_clk);
    @(posedge sys_clk);
  endtask
  task automatic complete_run;
    check(q.size() == 0, "result missing");
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ====
  // result watcher
  always @(negedge sys_clk) begin
    if (acc_done === 1'b1) begin
      n = q.pop_front();
      check(cyc - n.t0 == n.lat && acc_rdata === n.d, "bad latency or data");
    end
  end
  // ====
  // tests
  initial begin
    void'($urandom(32'h18f819e9));
    {acc_req, acc_we, legacy_mode, sector_split_select, lower_wait_select} = '0;
    {acc_addr, acc_wdata, upper_wait_select} = '0;
    {port_out_hi, port_dir_hi, port_out_ctl, port_dir_ctl} = $urandom;
    {port_out_ad, port_dir_ad, high_addr_release, bus_keeper_enable} = $urandom;
    ext_mem_enable = 1'b1;
    lr = 8'h00;
    rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) begin
      upper_wait_select <= i[1:0];
      d[i] = $urandom;
      acc(1'b1, {14'h2000, i[1:0]}, d[i], 4 + i, lr);
    end
    upper_wait_select <= 2'h2;
    for (i = 0; i < 4; i++) begin
      acc(1'b0, {14'h2000, i[1:0]}, 8'h00, 6, d[i]);
      lr = d[i];
    end
    $display("test external done");
    acc(1'b1, 16'h10ff, 8'h5a, 3, lr);
    acc(1'b1, 16'h1100, 8'h3c, 6, lr);
    $display("test boundary done");
    upper_wait_select <= 2'h1;
    for (i = 1; i < 8; i += 6) begin
      sector_split_select <= i[2:0];
      acc(1'b1, {i[2:0], 13'h0} - 16'h1, 8'h11, 4, lr);
      acc(1'b1, {i[2:0], 13'h0}, 8'h22, 5, lr);
    end
    high_addr_release <= 3'h4;
    port_dir_hi <= 8'h00;
    @(negedge sys_clk);
    check(high_addr_bus_oe === 8'h0f, "high lines not released");
    $display("test sectors done");
    @(posedge sys_clk);
    legacy_mode <= 1'b1;
    bus_keeper_enable <= 1'b1;
    upper_wait_select <= 2'h3;
    acc(1'b1, 16'h2000, 8'h33, 5, lr);
    upper_wait_select <= 2'h2;
    acc(1'b1, 16'h2000, 8'h44, 4, lr);
    @(negedge sys_clk);
    check(high_addr_bus_oe === 8'hff, "high width not fixed");
    check(mux_addr_data_bus_keeper === 1'b0, "keeper in legacy");
    $display("test legacy done");
    @(posedge sys_clk);
    legacy_mode <= 1'b0;
    ext_mem_enable <= 1'b0;
    port_out_ad <= 8'ha5;
    port_dir_ad <= 8'h0f;
    port_dir_hi <= 8'h3c;
    port_dir_ctl <= 3'h0;
    acc(1'b0, 16'h9000, 8'h00, 1, 8'h00);
    @(negedge sys_clk);
    check(mux_addr_data_bus_pullup === 8'ha0, "pull-up wrong");
    check(mux_addr_data_bus_keeper === 1'b1, "keeper off while disabled");
    check(high_addr_bus_oe === 8'h3c && {ale_oe, rd_n_oe, wr_n_oe} === 3'h0, "port dir");
    @(posedge sys_clk);
    legacy_mode <= 1'b1;
    @(negedge sys_clk);
    check({ale_oe, rd_n_oe, wr_n_oe} === 3'h7, "control pin not output");
    $display("test disabled done");
    complete_run;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    num_errors++;
    complete_run;
  end
endmodule // ebi_core_bench
bind ebi_core ebi_core_chk u_chk (.*);
`default_nettype wire

// ==== verification/ebi_core_chk.sv ====
`default_nettype none
module ebi_core_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic acc_req,
  input wire logic acc_we,
  input wire logic [15:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic acc_is_ext,
  input wire logic acc_busy,
  input wire logic acc_done,
  input wire logic ext_mem_enable,
  input wire logic legacy_mode,
  input wire logic [1:0] upper_wait_select,
  input wire logic [2:0] sector_split_select,
  input wire logic bus_keeper_enable,
  input wire logic [7:0] port_out_ad,
  input wire logic [7:0] port_dir_ad,
  input wire logic [7:0] mux_addr_data_bus_out,
  input wire logic [7:0] mux_addr_data_bus_oe,
  input wire logic mux_addr_data_bus_keeper,
  input wire logic ale_out,
  input wire logic rd_n_out,
  input wire logic wr_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====
  // cycle shape
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_addr;
    ale_out ##1 !ale_out;
  endsequence
  sequence s_rd3;
    !rd_n_out [*3] ##1 rd_n_out && acc_done;
  endsequence
  a_read_wait_len: assert property (
    acc_req && !acc_busy && acc_is_ext && ext_mem_enable && !legacy_mode && !acc_we
    && sector_split_select == 3'h0 && upper_wait_select == 2'h2 |=> s_addr ##1 s_rd3)
    else $error("read cycle shape wrong");
  a_int_quiet: assert property (
    ext_mem_enable && !acc_is_ext && acc_busy |-> rd_n_out && wr_n_out)
    else $error("strobe on internal access");
  a_addr_at_fall: assert property (
    ext_mem_enable && acc_is_ext && acc_busy && $fell(ale_out)
    |-> mux_addr_data_bus_oe == 8'hff && mux_addr_data_bus_out == acc_addr[7:0])
    else $error("low address invalid at latch fall");
  a_ale_low_data: assert property (
    ext_mem_enable && (!rd_n_out || !wr_n_out) |-> !ale_out)
    else $error("latch strobe high in data phase");
  a_read_release: assert property (
    ext_mem_enable && !rd_n_out |-> mux_addr_data_bus_oe == 8'h00)
    else $error("bus driven during read");
  a_write_data: assert property (
    ext_mem_enable && !wr_n_out
    |-> mux_addr_data_bus_oe == 8'hff && mux_addr_data_bus_out == acc_wdata)
    else $error("write data not driven");
  a_port_revert: assert property (
    !ext_mem_enable [*2]
    |-> mux_addr_data_bus_oe == port_dir_ad && mux_addr_data_bus_out == port_out_ad)
    else $error("disabled pins not ordinary port");
  a_keeper_sel: assert property (
    mux_addr_data_bus_keeper == (bus_keeper_enable && !legacy_mode))
    else $error("keeper enable wrong");
endmodule // ebi_core_chk
`default_nettype wire

// ==== verification/ebi_mem_model.sv ====
`default_nettype none
module ebi_mem_model (
  input wire logic sys_clk,
  input wire logic [7:0] mux_addr_data_bus_out,
  input wire logic [7:0] mux_addr_data_bus_oe,
  input wire logic [7:0] high_addr_bus_out,
  input wire logic ale_out,
  input wire logic rd_n_out,
  input wire logic wr_n_out,
  input wire logic mux_addr_data_bus_keeper,
  output wire logic [7:0] mux_addr_data_bus_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====
  // latch and memory
  logic [7:0] mem [0:65535];
  logic [7:0] lat_lo;
  logic [7:0] last_val = 8'h00;
  logic [7:0] far_val;
  always @* if (ale_out) lat_lo = mux_addr_data_bus_out;
  // released lines hold with keeper, else show a changed level
  assign far_val = !rd_n_out ? mem[{high_addr_bus_out, lat_lo}] :
    mux_addr_data_bus_keeper ? last_val : ~last_val;
  assign mux_addr_data_bus_in = (mux_addr_data_bus_oe & mux_addr_data_bus_out) |
    (~mux_addr_data_bus_oe & far_val);
  always @(posedge sys_clk) begin
    last_val <= mux_addr_data_bus_in;
    if (!wr_n_out)
      mem[{high_addr_bus_out, lat_lo}] <= mux_addr_data_bus_in;
  end
endmodule // ebi_mem_model
`default_nettype wire
